/* design/sar_adc_sequencer_control.sv */
`timescale 1ns/1ps
module sar_adc_sequencer_control (
	input  wire logic [0:0]  i_clk,
	input  wire logic [0:0]  i_rst_n,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [2:0]  i_timer_waveform_output,
	input  wire logic        i_ext_trigger_pin,
	input  wire logic [9:0]  i_cell_result,
	output logic             o_cell_power,
	output logic             o_cell_clk,
	output logic      [1:0]  o_cell_channel,
	output logic             o_cell_sample,
	output logic             o_cell_convert,
	output logic             o_cell_low_resolution,
	output logic             o_dma_request,
	output logic             o_dma_size16,
	output logic             o_irq
);
	// lowest enabled channel at or above a start index, bit 2 = found
	function automatic logic [2:0] first_from(input logic [3:0] m, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int i = adc_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && (i >= int'(from))) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction : first_from

	logic                    wait_q, wait_d;       // bus waitrequest
	logic [31:0]             rdata_q, rdata_d;     // bus read data
	logic [31:0]             rd_mux;               // selected read value
	logic                    do_rd, do_wr;         // access taken this edge
	logic [31:0]             wmask, wdat;          // byte-lane masked write data
	logic                    swrst, start_sw;      // control command pulses
	adc_seq_pkg::mode_t      mode_q, mode_d;       // mode configuration
	logic [3:0]              chen_q, chen_d;       // channel enables
	logic [31:0]             imr_q, imr_d;         // interrupt mask
	logic [5:0]              half_q, half_d;       // divider half-period count
	logic                    cclk_q, cclk_d;       // converter clock level
	logic                    tick;                 // one converter clock period ended
	adc_seq_pkg::seq_state_t state_q, state_d;     // sequencer state
	logic [7:0]              cnt_q, cnt_d;         // converter clocks left in phase
	logic [1:0]              chan_q, chan_d;       // channel being converted
	logic                    power_q, power_d;     // analog cell powered
	logic                    launch, done;         // sequence start, result ready
	logic                    trg_sel, trg_prev_q;  // selected hardware trigger
	logic                    start_req;            // any accepted start source
	logic [2:0]              nxt;                  // next channel search
	logic [9:0]              res;                  // result after resolution mask
	logic                    data_ready_flag_q, data_ready_flag_d;       // data ready flag
	logic                    general_overrun_flag_q, general_overrun_flag_d;     // general overrun flag
	logic [9:0]              last_q, last_d;       // last converted data
	logic [1:0]              lchan_q, lchan_d;     // channel of last result
	logic                    done_q;               // completion one cycle ago
	logic                    rd_sr, rd_lcdr;       // clearing reads
	logic                    dma_q, size16_q, irq_q;
	logic [31:0]             status;               // assembled status word
	wire  [3:0]              eoc_v, channel_overrun_flag_v;        // per-channel flags
	wire  [9:0]              cdr_v [4];            // per-channel results

	// slave accepts on the edge where waitrequest is seen low
	assign do_rd = i_avs_read & ~wait_q;
	assign do_wr = i_avs_write & ~wait_q;
	assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign wdat     = i_avs_writedata & wmask;
	assign swrst    = do_wr && (i_avs_address == adc_seq_pkg::OFF_CONTROL_CMD)
		&& wdat[adc_seq_pkg::CTRL_SWRST_BIT];
	assign start_sw = do_wr && (i_avs_address == adc_seq_pkg::OFF_CONTROL_CMD)
		&& wdat[adc_seq_pkg::CTRL_START_BIT];
	// a clear is skipped if a result landed after the read snapshot
	assign rd_sr   = do_rd && (i_avs_address == adc_seq_pkg::OFF_STATUS) && !done_q;
	assign rd_lcdr = do_rd && (i_avs_address == adc_seq_pkg::OFF_LAST_RESULT) && !done_q;

	// status word layout
	assign status = adc_seq_pkg::STATUS_DMA_IDLE
		| {14'h0000, general_overrun_flag_q, data_ready_flag_q, 4'h0, channel_overrun_flag_v, 4'h0, eoc_v};

	// read multiplexer, unmapped and write-only offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_avs_address)
			adc_seq_pkg::OFF_MODE_CONFIG: rd_mux = {4'h0, mode_q.sample_hold_time_field, 3'h0,
				mode_q.startup, 2'h0, mode_q.clock_divider_field, 2'h0, mode_q.sleep,
				mode_q.low_resolution_bit, mode_q.trigger_select_field, mode_q.hw_trigger_enable_bit};
			adc_seq_pkg::OFF_CHEN_STATE:  rd_mux = {28'h0000000, chen_q};
			adc_seq_pkg::OFF_STATUS:      rd_mux = status;
			adc_seq_pkg::OFF_LAST_RESULT: rd_mux = {22'h000000, last_q};
			adc_seq_pkg::OFF_IRQ_MASK:    rd_mux = imr_q;
			default: begin
				if (i_avs_address >= adc_seq_pkg::OFF_CH_RESULT0
					&& i_avs_address <= adc_seq_pkg::OFF_CH_RESULT3
					&& i_avs_address[1:0] == 2'h0) begin
					rd_mux = {22'h000000, cdr_v[i_avs_address[3:2]]};
				end
			end
		endcase
	end

	// bus handshake: one wait cycle, then data with waitrequest low
	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if ((i_avs_read || i_avs_write) && wait_q) begin
			wait_d  = 1'b0;
			rdata_d = i_avs_read ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// configuration registers: mode, channel enables, interrupt mask
	always_comb begin
		mode_d = mode_q;
		chen_d = chen_q;
		imr_d  = imr_q;
		if (do_wr && i_avs_address == adc_seq_pkg::OFF_MODE_CONFIG) begin
			mode_d.hw_trigger_enable_bit   = wmask[0] ? wdat[adc_seq_pkg::MODE_HW_TRIGGER_ENABLE_BIT_BIT] : mode_q.hw_trigger_enable_bit;
			mode_d.trigger_select_field  = wmask[0] ? wdat[adc_seq_pkg::MODE_TRIGGER_SELECT_FIELD_LSB +: 3] : mode_q.trigger_select_field;
			mode_d.low_resolution_bit  = wmask[0] ? wdat[adc_seq_pkg::MODE_LOW_RESOLUTION_BIT_BIT] : mode_q.low_resolution_bit;
			mode_d.sleep   = wmask[0] ? wdat[adc_seq_pkg::MODE_SLEEP_BIT] : mode_q.sleep;
			mode_d.clock_divider_field = wmask[8] ? wdat[adc_seq_pkg::MODE_CLOCK_DIVIDER_FIELD_LSB +: 6] : mode_q.clock_divider_field;
			mode_d.startup = wmask[16] ? wdat[adc_seq_pkg::MODE_STARTUP_LSB +: 5] : mode_q.startup;
			mode_d.sample_hold_time_field   = wmask[24] ? wdat[adc_seq_pkg::MODE_SAMPLE_HOLD_TIME_FIELD_LSB +: 4] : mode_q.sample_hold_time_field;
		end
		if (do_wr && i_avs_address == adc_seq_pkg::OFF_CHEN_SET) begin
			chen_d = chen_q | wdat[3:0];
		end
		if (do_wr && i_avs_address == adc_seq_pkg::OFF_CHEN_CLEAR) begin
			chen_d = chen_q & ~wdat[3:0];
		end
		if (do_wr && i_avs_address == adc_seq_pkg::OFF_IRQ_SET) begin
			imr_d = (imr_q | wdat) & adc_seq_pkg::IRQ_VALID_BITS;
		end
		if (do_wr && i_avs_address == adc_seq_pkg::OFF_IRQ_CLEAR) begin
			imr_d = imr_q & ~wdat;
		end
		// software reset returns to full resolution, nothing enabled
		if (swrst) begin
			mode_d = adc_seq_pkg::MODE_RESET[20:0];
			chen_d = 4'h0;
			imr_d  = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= adc_seq_pkg::MODE_RESET[20:0]; // full resolution after reset
			chen_q <= 4'h0;
			imr_q  <= 32'h0000_0000;
		end else begin
			mode_q <= mode_d;
			chen_q <= chen_d;
			imr_q  <= imr_d;
		end
	end

	// converter clock divider, restarted on launch so phases are exact
	always_comb begin
		tick   = (half_q >= mode_q.clock_divider_field) && cclk_q; // period 2*(clock_divider_field+1)
		half_d = (half_q >= mode_q.clock_divider_field) ? 6'h00 : half_q + 6'h01;
		cclk_d = (half_q >= mode_q.clock_divider_field) ? ~cclk_q : cclk_q;
		if (launch || swrst) begin
			half_d = 6'h00;
			cclk_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			half_q <= 6'h00;
			cclk_q <= 1'b0;
		end else begin
			half_q <= half_d;
			cclk_q <= cclk_d;
		end
	end

	// hardware trigger source select and rising edge
	always_comb begin
		case (mode_q.trigger_select_field)
			adc_seq_pkg::TRG_TIMER0: trg_sel = i_timer_waveform_output[0];
			adc_seq_pkg::TRG_TIMER1: trg_sel = i_timer_waveform_output[1];
			adc_seq_pkg::TRG_TIMER2: trg_sel = i_timer_waveform_output[2];
			adc_seq_pkg::TRG_EXT:    trg_sel = i_ext_trigger_pin;
			default:                 trg_sel = 1'b0; // reserved codes never fire
		endcase
		// software start always works alongside the hardware source
		start_req = start_sw || (mode_q.hw_trigger_enable_bit && trg_sel && !trg_prev_q);
	end

	// conversion sequencer
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		chan_d  = chan_q;
		power_d = power_q;
		launch  = 1'b0;
		done    = 1'b0;
		nxt     = first_from(chen_q, 3'h0);
		case (state_q)
			adc_seq_pkg::ST_IDLE: begin
				// a start converts every enabled channel
				if (start_req && (chen_q != 4'h0)) begin
					launch  = 1'b1;
					power_d = 1'b1;
					if (!power_q) begin
						state_d = adc_seq_pkg::ST_STARTUP; // cell wakes first
						cnt_d   = {mode_q.startup, 3'h7}; // 8*(startup+1) periods
					end else begin
						state_d = adc_seq_pkg::ST_SAMPLE;
						chan_d  = nxt[1:0]; // lowest channel first
						cnt_d   = {4'h0, mode_q.sample_hold_time_field};
					end
				end
			end
			adc_seq_pkg::ST_STARTUP: begin
				if (tick) begin
					cnt_d = cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						state_d = nxt[2] ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
						power_d = nxt[2] || !mode_q.sleep; // nothing left: sleep again
						chan_d  = nxt[1:0];
						cnt_d   = {4'h0, mode_q.sample_hold_time_field};
					end
				end
			end
			adc_seq_pkg::ST_SAMPLE: begin
				if (tick) begin
					cnt_d = cnt_q - 8'h01; // sample_hold_time_field+1 periods
					if (cnt_q == 8'h00) begin
						state_d = adc_seq_pkg::ST_CONVERT;
						cnt_d   = adc_seq_pkg::CONV_CYCLES - 8'h01;
					end
				end
			end
			adc_seq_pkg::ST_CONVERT: begin
				nxt = first_from(chen_q, {1'b0, chan_q} + 3'h1);
				if (tick) begin
					cnt_d = cnt_q - 8'h01;
					if (cnt_q == 8'h00) begin
						done = 1'b1;
						// ascending order, then idle until the next start
						if (nxt[2]) begin
							state_d = adc_seq_pkg::ST_SAMPLE;
							chan_d  = nxt[1:0];
							cnt_d   = {4'h0, mode_q.sample_hold_time_field};
						end else begin
							state_d = adc_seq_pkg::ST_IDLE;
							power_d = !mode_q.sleep; // sleep powers down after sequence
						end
					end
				end
			end
			default: state_d = adc_seq_pkg::ST_IDLE;
		endcase
		// starts outside idle fall through unused
		if (swrst) begin
			state_d = adc_seq_pkg::ST_IDLE;
			power_d = 1'b0;
			chan_d  = 2'h0;
			cnt_d   = 8'h00;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q    <= adc_seq_pkg::ST_IDLE;
			cnt_q      <= 8'h00;
			chan_q     <= 2'h0;
			power_q    <= 1'b0;
			trg_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			chan_q     <= chan_d;
			power_q    <= power_d;
			trg_prev_q <= trg_sel;
		end
	end

	// result masking: low resolution keeps eight bits
	assign res = mode_q.low_resolution_bit ? {2'b00, i_cell_result[7:0]} : i_cell_result;

	// per-channel result, end-of-conversion and overrun
	for (genvar g = 0; g < adc_seq_pkg::NUM_CH; g++) begin : g_ch
		logic       eoc_q, eoc_d, channel_overrun_flag_q, channel_overrun_flag_d;
		logic [9:0] cdr_q, cdr_d;
		logic       hit, rd_cdr;
		always_comb begin
			hit    = done && (chan_q == 2'(g));
			rd_cdr = do_rd && !done_q
				&& (i_avs_address == adc_seq_pkg::OFF_CH_RESULT0 + 8'(4 * g));
			cdr_d  = hit ? res : cdr_q;
			eoc_d  = eoc_q;
			channel_overrun_flag_d = channel_overrun_flag_q;
			if (rd_cdr || (rd_lcdr && lchan_q == 2'(g))) begin
				eoc_d = 1'b0;
			end
			if (rd_sr) begin
				channel_overrun_flag_d = 1'b0;
			end
			if (hit) begin
				eoc_d  = 1'b1; // set beats a same-cycle clear
				channel_overrun_flag_d = channel_overrun_flag_d | eoc_q; // unread result overwritten
			end
			if (swrst) begin
				eoc_d  = 1'b0;
				channel_overrun_flag_d = 1'b0;
				cdr_d  = 10'h000;
			end
		end
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				eoc_q  <= 1'b0;
				channel_overrun_flag_q <= 1'b0;
				cdr_q  <= 10'h000;
			end else begin
				eoc_q  <= eoc_d;
				channel_overrun_flag_q <= channel_overrun_flag_d;
				cdr_q  <= cdr_d;
			end
		end
		assign eoc_v[g]  = eoc_q;
		assign channel_overrun_flag_v[g] = channel_overrun_flag_q;
		assign cdr_v[g]  = cdr_q;
	end

	// shared flags, last result, dma request and interrupt
	always_comb begin
		data_ready_flag_d  = data_ready_flag_q;
		general_overrun_flag_d = general_overrun_flag_q;
		last_d  = last_q;
		lchan_d = lchan_q;
		if (rd_lcdr) begin
			data_ready_flag_d = 1'b0;
		end
		if (rd_sr) begin
			general_overrun_flag_d = 1'b0;
		end
		if (done) begin
			last_d  = res;
			lchan_d = chan_q;
			data_ready_flag_d  = 1'b1;
			general_overrun_flag_d = general_overrun_flag_d | data_ready_flag_q;
		end
		if (swrst) begin
			data_ready_flag_d  = 1'b0;
			general_overrun_flag_d = 1'b0;
			last_d  = 10'h000;
			lchan_d = 2'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_ready_flag_q   <= 1'b0;
			general_overrun_flag_q  <= 1'b0;
			last_q   <= 10'h000;
			lchan_q  <= 2'h0;
			done_q   <= 1'b0;
			dma_q    <= 1'b0;
			size16_q <= 1'b1;
			irq_q    <= 1'b0;
		end else begin
			data_ready_flag_q   <= data_ready_flag_d;
			general_overrun_flag_q  <= general_overrun_flag_d;
			last_q   <= last_d;
			lchan_q  <= lchan_d;
			done_q   <= done;
			dma_q    <= data_ready_flag_d && !data_ready_flag_q;
			size16_q <= !mode_d.low_resolution_bit;
			irq_q    <= (imr_q & status) != 32'h0000_0000;
		end
	end

	// analog cell control outputs, all registered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cell_power   <= 1'b0;
			o_cell_channel <= 2'h0;
			o_cell_sample  <= 1'b0;
			o_cell_convert <= 1'b0;
		end else begin
			o_cell_power   <= power_d;
			o_cell_channel <= chan_d;
			o_cell_sample  <= state_d == adc_seq_pkg::ST_SAMPLE;
			o_cell_convert <= state_d == adc_seq_pkg::ST_CONVERT;
		end
	end

	assign o_avs_readdata        = rdata_q;
	assign o_avs_waitrequest     = wait_q;
	assign o_cell_clk            = cclk_q;
	assign o_cell_low_resolution = mode_q.low_resolution_bit;
	assign o_dma_request         = dma_q;
	assign o_dma_size16          = size16_q;
	assign o_irq                 = irq_q;

	// helper: converter periods seen in the convert phase
	logic [7:0] conv_ticks_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			conv_ticks_q <= 8'h00;
		end else if (state_q != adc_seq_pkg::ST_CONVERT) begin
			conv_ticks_q <= 8'h00;
		end else if (tick) begin
			conv_ticks_q <= conv_ticks_q + 8'h01;
		end
	end

	// helper: master clocks since the last converter period boundary
	logic [7:0] per_q;
	logic       per_ok_q;   // no prescaler change inside the running period
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			per_q    <= 8'h00;
			per_ok_q <= 1'b1;
		end else begin
			per_q    <= (tick || launch || swrst) ? 8'h00 : per_q + 8'h01;
			per_ok_q <= tick || launch || swrst
				|| (per_ok_q && mode_d.clock_divider_field == mode_q.clock_divider_field);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_conv_length: assert property (done |-> conv_ticks_q == 8'h09)
		else $error("conversion did not last ten converter clocks");
	a_div_period: assert property (tick && per_ok_q
		|-> per_q == {1'b0, mode_q.clock_divider_field, 1'b1})
		else $error("converter clock period is not twice prescaler plus one");
	a_low_resolution_bit_zero: assert property (done && mode_q.low_resolution_bit |=> last_q[9:8] == 2'b00)
		else $error("low resolution result has upper bits set");
	a_last_store: assert property (done && !swrst
		|=> last_q == $past(res) && cdr_v[lchan_q] == $past(res))
		else $error("result not stored in both registers");
	a_done_flags: assert property (done && !swrst
		|=> data_ready_flag_q && eoc_v[$past(chan_q)])
		else $error("completion did not set ready and eoc");
	a_dma_pulse: assert property ($rose(data_ready_flag_q) |-> o_dma_request ##1 !o_dma_request)
		else $error("dma request not a pulse on ready rise");
	a_general_overrun_flag_set: assert property (done && data_ready_flag_q && !swrst |=> general_overrun_flag_q)
		else $error("general overrun missed");
	a_sr_clear: assert property (rd_sr && !done |=> !general_overrun_flag_q && channel_overrun_flag_v == 4'h0)
		else $error("status read left overrun set");
	a_busy_ignore: assert property (state_q != adc_seq_pkg::ST_IDLE
		&& start_req && !tick && !swrst
		|=> state_q == $past(state_q) && chan_q == $past(chan_q))
		else $error("start disturbed a running sequence");
	a_sleep_down: assert property (done && state_d == adc_seq_pkg::ST_IDLE
		&& mode_q.sleep && !swrst |=> !o_cell_power)
		else $error("cell left powered after sleep sequence");
endmodule : sar_adc_sequencer_control

/* inc/adc_seq_pkg.sv */
package adc_seq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CONTROL_CMD   = 8'h00;
	localparam logic [7:0] OFF_MODE_CONFIG   = 8'h04;
	localparam logic [7:0] OFF_CHEN_SET      = 8'h10;
	localparam logic [7:0] OFF_CHEN_CLEAR    = 8'h14;
	localparam logic [7:0] OFF_CHEN_STATE    = 8'h18;
	localparam logic [7:0] OFF_STATUS        = 8'h1c;
	localparam logic [7:0] OFF_LAST_RESULT   = 8'h20;
	localparam logic [7:0] OFF_IRQ_SET       = 8'h24;
	localparam logic [7:0] OFF_IRQ_CLEAR     = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK      = 8'h2c;
	localparam logic [7:0] OFF_CH_RESULT0    = 8'h30;
	localparam logic [7:0] OFF_CH_RESULT3    = 8'h3c;
	// control command bits
	localparam int CTRL_SWRST_BIT   = 0;
	localparam int CTRL_START_BIT   = 1;
	// mode_config field positions
	localparam int MODE_HW_TRIGGER_ENABLE_BIT_BIT   = 0;
	localparam int MODE_TRIGGER_SELECT_FIELD_LSB  = 1;
	localparam int MODE_LOW_RESOLUTION_BIT_BIT  = 4;
	localparam int MODE_SLEEP_BIT   = 5;
	localparam int MODE_CLOCK_DIVIDER_FIELD_LSB = 8;
	localparam int MODE_STARTUP_LSB = 16;
	localparam int MODE_SAMPLE_HOLD_TIME_FIELD_LSB   = 24;
	// field widths and sizes
	localparam int NUM_CH     = 4;
	localparam int DATA_W     = 10;
	localparam int CLOCK_DIVIDER_FIELD_W  = 6;
	localparam int STARTUP_W  = 5;
	localparam int SAMPLE_HOLD_TIME_FIELD_W    = 4;
	localparam int TRIGGER_SELECT_FIELD_W   = 3;
	// reset values and valid interrupt mask bits
	localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
	localparam logic [31:0] STATUS_DMA_IDLE = 32'h000c_0000;
	localparam logic [31:0] IRQ_VALID_BITS  = 32'h0003_0f0f;
	// status field positions
	localparam int ST_CHANNEL_OVERRUN_FLAG_LSB  = 8;
	localparam int ST_DATA_READY_FLAG_BIT  = 16;
	localparam int ST_GENERAL_OVERRUN_FLAG_BIT = 17;
	// timing in converter clock periods
	localparam logic [7:0] CONV_CYCLES = 8'h0a;
	// trigger select codes
	localparam logic [2:0] TRG_TIMER0 = 3'h0;
	localparam logic [2:0] TRG_TIMER1 = 3'h1;
	localparam logic [2:0] TRG_TIMER2 = 3'h2;
	localparam logic [2:0] TRG_EXT    = 3'h6;

	// decoded mode_config contents
	typedef struct packed {
		logic [SAMPLE_HOLD_TIME_FIELD_W-1:0]   sample_hold_time_field;
		logic [STARTUP_W-1:0] startup;
		logic [CLOCK_DIVIDER_FIELD_W-1:0] clock_divider_field;
		logic                 sleep;
		logic                 low_resolution_bit;
		logic [TRIGGER_SELECT_FIELD_W-1:0]  trigger_select_field;
		logic                 hw_trigger_enable_bit;
	} mode_t;

	// conversion sequencer states
	typedef enum {ST_IDLE, ST_STARTUP, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage : adc_seq_pkg

/* test/adc_cell_model.sv */
`timescale 1ns/1ps
// behavioural analog cell: answers a fixed code for each selected channel
module adc_cell_model (
	input  wire logic       i_channel_lsb,
	input  wire logic       i_channel_msb,
	input  wire logic       i_low_res,
	output logic      [9:0] o_result
);
	// low resolution cell answers eight bits in the low part
	always_comb begin
		if (i_low_res) begin
			o_result = {2'h0, 6'h2a, i_channel_msb, i_channel_lsb};
		end else begin
			o_result = {2'h2, 6'h2a, i_channel_msb, i_channel_lsb};
		end
	end
endmodule : adc_cell_model

/* test/sar_adc_sequencer_control_tb.sv */
`timescale 1ns/1ps
module sar_adc_sequencer_control_tb;
	logic        i_clk = 1'b0;      // master clock
	logic        i_rst_n = 1'b0;    // reset, low active
	logic [7:0]  addr = 8'h00;      // bus address
	logic        rd = 1'b0;         // bus read
	logic        we = 1'b0;         // bus write
	logic [31:0] wdata = 32'h0;     // bus write data
	logic [2:0]  trg = 3'h0;        // timer trigger lines
	logic        ext = 1'b0;        // external trigger line
	logic [31:0] rdata, q;          // read data, last read value
	logic        waitreq, irq, dma, size16, low_resolution_bit;
	logic [1:0]  chan;              // selected channel
	logic [9:0]  result;            // cell answer
	logic        power, cclk;       // cell power and converter clock
	logic        smp, cnv;          // cell sample and convert phases
	logic        dma_seen = 1'b0;   // a transfer request was seen
	int          err_total = 0;     // mismatches
	int          cmp_count = 0;     // comparisons
	int          cyc = 0;           // cycle counter for the timeout
	int          codes[4] = '{0, 1, 2, 6};

	always #12.5 i_clk = ~i_clk;

	sar_adc_sequencer_control dut_u (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(we), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_timer_waveform_output(trg), .i_ext_trigger_pin(ext), .i_cell_result(result),
		.o_cell_power(power), .o_cell_clk(cclk), .o_cell_channel(chan), .o_cell_sample(smp),
		.o_cell_convert(cnv), .o_cell_low_resolution(low_resolution_bit), .o_dma_request(dma),
		.o_dma_size16(size16), .o_irq(irq));

	adc_cell_model cell_u (.i_channel_lsb(chan[0]), .i_channel_msb(chan[1]),
		.i_low_res(low_resolution_bit), .o_result(result));

	// remember transfer requests; cut a hang short
	always @(posedge i_clk) begin
		if (dma === 1'b1) dma_seen <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one bus access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		rd <= !wr;
		we <= wr;
		do @(posedge i_clk); while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		we <= 1'b0;
	endtask : bus

	// wait for the interrupt line under a bound
	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge i_clk);
			n++;
		end
		chk("irq", 32'h1, {31'h0, irq});
	endtask : wait_irq

	task t_reset;
		chk("size16", 32'h1, {31'h0, size16});
		bus(0, 8'h04, 0); chk("mode", 32'h0, q);
		bus(0, 8'h1c, 0); chk("status", 32'h000c0000, q);
		bus(0, 8'h18, 0); chk("chen", 32'h0, q);
		bus(0, 8'h2c, 0); chk("mask", 32'h0, q);
		bus(0, 8'h40, 0); chk("unmapped", 32'h0, q);
	endtask : t_reset

	// two channels, software start given twice, the second while busy
	task t_sequence;
		bus(1, 8'h24, 32'h4); bus(0, 8'h2c, 0); chk("mask", 32'h4, q);
		bus(1, 8'h10, 32'h5); bus(0, 8'h18, 0); chk("chen", 32'h5, q);
		bus(1, 8'h00, 32'h2);
		bus(1, 8'h00, 32'h2);
		wait_irq();
		repeat (100) @(posedge i_clk);
		bus(0, 8'h1c, 0); chk("status", 32'h000f0005, q);
		chk("dma", 32'h1, {31'h0, dma_seen});
		bus(0, 8'h30, 0); chk("ch0", 32'h2a8, q);
		bus(0, 8'h38, 0); chk("ch2", 32'h2aa, q);
		bus(0, 8'h20, 0); chk("last", 32'h2aa, q);
		bus(0, 8'h1c, 0); chk("status", 32'h000c0000, q);
	endtask : t_sequence

	// channel 0 left unread across two sequences
	task t_overrun;
		bus(1, 8'h00, 32'h2);
		wait_irq();
		bus(0, 8'h20, 0);
		repeat (2) @(posedge i_clk);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1, 8'h00, 32'h2);
		wait_irq();
		bus(0, 8'h1c, 0); chk("channel_overrun_flag", 32'h00020100, q & 32'h00020100);
		bus(0, 8'h1c, 0); chk("channel_overrun_flag_clr", 32'h0, q & 32'h00020f00);
		bus(0, 8'h20, 0);
	endtask : t_overrun

	// each trigger code, low resolution, then a reserved code
	task t_triggers;
		foreach (codes[i]) begin
			bus(1, 8'h04, 32'h11 | (codes[i] << 1));
			@(posedge i_clk);
			if (codes[i] == 6) ext <= 1'b1;
			else trg[codes[i]] <= 1'b1; // clean waveform-style level
			wait_irq();
			chk("size16", 32'h0, {31'h0, size16});
			bus(0, 8'h20, 0); chk("last_low", 32'h0aa, q);
			trg <= 3'h0;
			ext <= 1'b0;
		end
		bus(1, 8'h04, 32'h17);
		@(posedge i_clk);
		trg <= 3'h7;
		ext <= 1'b1;
		repeat (200) @(posedge i_clk);
		chk("reserved", 32'h0, {31'h0, irq});
		bus(1, 8'h00, 32'h2);
		wait_irq();
	endtask : t_triggers

	// software reset, then one sleep-mode sequence timed from the cell outputs
	task t_sleep;
		logic [31:0] np, nk, ns, nc;
		np = 32'h0;
		nk = 32'h0;
		ns = 32'h0;
		nc = 32'h0;
		bus(1, 8'h00, 32'h1);
		bus(0, 8'h1c, 0);
		chk("swrst", 32'h000c0000, q);
		chk("size16_full", 32'h1, {31'h0, size16});
		bus(1, 8'h04, 32'h01000120);
		bus(1, 8'h10, 32'h2);
		bus(1, 8'h00, 32'h2);
		repeat (150) begin
			@(posedge i_clk);
			np = np + power;
			nk = nk + (power & cclk);
			ns = ns + smp;
			nc = nc + cnv;
		end
		chk("powered", 32'h50, np);
		chk("clk_high", 32'h28, nk);
		chk("sample", 32'h8, ns);
		chk("convert", 32'h28, nc);
		chk("power_down", 32'h0, {31'h0, power});
		bus(0, 8'h34, 0);
		chk("ch1", 32'h2a9, q);
	endtask : t_sleep

	task stop_test;
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_sequence();
		t_overrun();
		t_triggers();
		t_sleep();
		stop_test();
	end
endmodule : sar_adc_sequencer_control_tb
